/* File: core/tc8_pkg.sv */
package tc8_pkg;

    // Data and address widths
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned RATE_W = 3;
    localparam int unsigned HOLD_W = 2;

    // Register offsets on the plain register port
    localparam logic [ADDR_W-1:0] OFS_OPTION     = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_COUNT      = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_INTCTL     = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 3'h4;

    // Field positions in timer_option_control
    localparam int unsigned OPT_RATE_LSB   = 0;
    localparam int unsigned OPT_ASSIGN_BIT = 3;
    localparam int unsigned OPT_EDGE_BIT   = 4;
    localparam int unsigned OPT_SRC_BIT    = 5;

    // Field positions in interrupt_control_flags
    localparam int unsigned INT_FLAG_BIT   = 2;
    localparam int unsigned INT_ENABLE_BIT = 5;

    // Field position in interrupt status and mask
    localparam int unsigned IRQ_OVF_BIT = 0;

    // Reset values
    localparam logic [DATA_W-1:0] OPTION_RST = 8'hff;
    localparam logic [DATA_W-1:0] INTCTL_RST = 8'h00;
    localparam logic [DATA_W-1:0] COUNT_RST  = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE  = 8'h00;
    localparam logic [DATA_W-1:0] ONE_BYTE   = 8'h01;
    localparam logic [DATA_W-1:0] COUNT_TOP  = 8'hff;

    // Prescaler mask bases, timer side starts at 1:2
    localparam logic [15:0] MASK_BASE_TIMER = 16'h0002;
    localparam logic [15:0] MASK_BASE_WDT   = 16'h0001;
    localparam logic [15:0] MASK_ONE        = 16'h0001;

    // Timing
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned INSTR_PERIOD_NS  = 40;
    localparam int unsigned PHASES_PER_INSTR = INSTR_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [HOLD_W-1:0] WRITE_HOLD_INSTR = 2'h2;
    localparam logic [HOLD_W-1:0] HOLD_ONE         = 2'h1;
    localparam logic [HOLD_W-1:0] HOLD_NONE        = 2'h0;

    // Internal phase clocks of one instruction cycle
    typedef enum logic [1:0] {
        TC8_Q1 = 2'b00,
        TC8_Q2 = 2'b01,
        TC8_Q3 = 2'b10,
        TC8_Q4 = 2'b11
    } tc8_phase_e;

    // Register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } tc8_bus_req_s;

    // Prescaler state
    typedef struct packed {
        logic [DATA_W-1:0] cnt;
    } tc8_presc_s;

    localparam tc8_presc_s PRESC_RST = '{cnt: 8'h00};

    // Timer core state
    typedef struct packed {
        tc8_phase_e        phase;
        logic              pin_s1;
        logic              pin_s2;
        logic              pin_prev;
        logic              ext_pend;
        logic [HOLD_W-1:0] hold;
        logic [DATA_W-1:0] count;
        logic [DATA_W-1:0] option;
        logic [DATA_W-1:0] intctl;
        logic [DATA_W-1:0] rdata;
    } tc8_core_s;

    localparam tc8_core_s CORE_RST = '{
        phase:    TC8_Q1,
        pin_s1:   1'b0,
        pin_s2:   1'b0,
        pin_prev: 1'b0,
        ext_pend: 1'b0,
        hold:     2'h0,
        count:    COUNT_RST,
        option:   OPTION_RST,
        intctl:   INTCTL_RST,
        rdata:    8'h00
    };

endpackage

/* File: core/tc8_prescaler.sv */
`timescale 1ns/10ps
`default_nettype none

module tc8_prescaler (
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        reset_n,
    // Control
    input  wire logic                        clear,
    input  wire logic [tc8_pkg::DATA_W-1:0]  rate_mask,
    // Ticks
    input  wire logic                        tick_in,
    output logic                             tick_out
);

    tc8_pkg::tc8_presc_s s_r;
    tc8_pkg::tc8_presc_s s_nxt;

    // A tick passes when all masked low bits are ones
    assign tick_out = tick_in && !clear
                      && ((s_r.cnt & rate_mask) == rate_mask);

    always_comb
    begin
        s_nxt = s_r;
        if (clear)
        begin
            s_nxt.cnt = tc8_pkg::ZERO_BYTE;
        end
        else if (tick_in)
        begin
            s_nxt.cnt = s_r.cnt + tc8_pkg::ONE_BYTE;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            s_r <= tc8_pkg::PRESC_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

endmodule

`default_nettype wire

/* File: core/tc8_timer.sv */
`timescale 1ns/10ps
`default_nettype none

module tc8_timer (
    // Clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         reset_n,
    // Register port
    input  wire tc8_pkg::tc8_bus_req_s        bus_req,
    output logic [tc8_pkg::DATA_W-1:0]        bus_rdata,
    // Count pin
    input  wire logic                         external_count_pin,
    // Core and watchdog
    input  wire logic                         sleep_mode,
    input  wire logic                         watchdog_base_tick,
    input  wire logic                         watchdog_clear_instruction,
    output logic                              watchdog_tick,
    // Interrupt
    output logic                              irq
);

    localparam int unsigned RATE_CODES = 1 << tc8_pkg::RATE_W;

    tc8_pkg::tc8_core_s s_r;
    tc8_pkg::tc8_core_s s_nxt;

    logic                              instr_tick;
    logic                              sample_slot;
    logic                              wr_option;
    logic                              wr_count;
    logic                              wr_intctl;
    logic                              wr_status;
    logic                              wr_mask;
    logic                              to_timer;
    logic                              ext_mode;
    logic                              edge_fall;
    logic                              pin_edge;
    logic                              timer_src;
    logic                              presc_in;
    logic                              presc_clear;
    logic                              presc_out;
    logic                              timer_event;
    logic                              count_step;
    logic                              count_inc;
    logic                              overflow;
    logic                              flag;
    logic                              enable;
    logic [tc8_pkg::RATE_W-1:0]        rate;
    logic [tc8_pkg::DATA_W-1:0]        presc_mask;
    logic [tc8_pkg::DATA_W-1:0]        read_mux;
    logic                              pin_rise;
    logic                              pin_fall;
    logic [tc8_pkg::DATA_W-1:0]        timer_mask [RATE_CODES];
    logic [tc8_pkg::DATA_W-1:0]        wdt_mask   [RATE_CODES];

    // Instruction cycle is the last phase of four
    assign instr_tick  = (s_r.phase == tc8_pkg::TC8_Q4);
    assign sample_slot = (s_r.phase == tc8_pkg::TC8_Q2)
                         || (s_r.phase == tc8_pkg::TC8_Q4);

    // Write decode; unmapped offsets raise no strobe at all
    always_comb
    begin
        wr_option = 1'b0;
        wr_count  = 1'b0;
        wr_intctl = 1'b0;
        wr_status = 1'b0;
        wr_mask   = 1'b0;
        if (bus_req.wr)
        begin
            case (bus_req.addr)
                tc8_pkg::OFS_OPTION:
                begin
                    wr_option = 1'b1;
                end
                tc8_pkg::OFS_COUNT:
                begin
                    wr_count = 1'b1;
                end
                tc8_pkg::OFS_INTCTL:
                begin
                    wr_intctl = 1'b1;
                end
                tc8_pkg::OFS_IRQ_STATUS:
                begin
                    wr_status = 1'b1;
                end
                tc8_pkg::OFS_IRQ_MASK:
                begin
                    wr_mask = 1'b1;
                end
                default:
                begin
                    wr_option = 1'b0;
                end
            endcase
        end
    end

    // Option fields
    assign to_timer  = !s_r.option[tc8_pkg::OPT_ASSIGN_BIT];
    assign ext_mode  = s_r.option[tc8_pkg::OPT_SRC_BIT];
    assign edge_fall = s_r.option[tc8_pkg::OPT_EDGE_BIT];
    assign rate      = s_r.option[tc8_pkg::OPT_RATE_LSB +: tc8_pkg::RATE_W];

    assign flag   = s_r.intctl[tc8_pkg::INT_FLAG_BIT];
    assign enable = s_r.intctl[tc8_pkg::INT_ENABLE_BIT];

    // Edge on the synchronised pin, chosen polarity
    assign pin_rise = !s_r.pin_prev && s_r.pin_s2;
    assign pin_fall = s_r.pin_prev && !s_r.pin_s2;
    assign pin_edge = edge_fall ? pin_fall : pin_rise;

    // Timer source before any prescaling
    assign timer_src = ext_mode ? pin_edge
                                : instr_tick;

    // Timer source frozen in sleep, watchdog keeps its own base;
    // the clear source follows the assignment as well
    always_comb
    begin
        if (to_timer)
        begin
            presc_in    = timer_src && !sleep_mode;
            presc_clear = wr_count;
        end
        else
        begin
            presc_in    = watchdog_base_tick;
            presc_clear = watchdog_clear_instruction;
        end
    end

    // Mask per rate code; the timer side sits one doubling higher,
    // which is why a 1:1 timer rate needs the prescaler moved away
    for (genvar g = 0; g < RATE_CODES; g++)
    begin : g_rate
        assign timer_mask[g] = 8'((tc8_pkg::MASK_BASE_TIMER << g)
                                  - tc8_pkg::MASK_ONE);
        assign wdt_mask[g]   = 8'((tc8_pkg::MASK_BASE_WDT << g)
                                  - tc8_pkg::MASK_ONE);
    end

    assign presc_mask = to_timer ? timer_mask[rate]
                                 : wdt_mask[rate];

    tc8_prescaler u_presc (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .clear     (presc_clear),
        .rate_mask (presc_mask),
        .tick_in   (presc_in),
        .tick_out  (presc_out)
    );

    // Prescaler on watchdog bypasses it for the timer, and the
    // watchdog runs undivided while the timer holds the prescaler
    always_comb
    begin
        if (to_timer)
        begin
            timer_event   = presc_out;
            watchdog_tick = watchdog_base_tick;
        end
        else
        begin
            timer_event   = timer_src && !sleep_mode;
            watchdog_tick = presc_out;
        end
    end

    // External path only advances on a sampling phase
    assign count_step = ext_mode
                        ? (sample_slot && s_r.ext_pend)
                        : timer_event;

    assign count_inc = count_step
                       && (s_r.hold == tc8_pkg::HOLD_NONE)
                       && !sleep_mode
                       && !wr_count;

    assign overflow = count_inc && (s_r.count == tc8_pkg::COUNT_TOP);

    // Read selection, unmapped offsets read zero
    always_comb
    begin
        read_mux = tc8_pkg::ZERO_BYTE;
        case (bus_req.addr)
            tc8_pkg::OFS_OPTION:
            begin
                read_mux = s_r.option;
            end
            tc8_pkg::OFS_COUNT:
            begin
                read_mux = s_r.count;
            end
            tc8_pkg::OFS_INTCTL:
            begin
                read_mux = s_r.intctl;
            end
            tc8_pkg::OFS_IRQ_STATUS:
            begin
                read_mux[tc8_pkg::IRQ_OVF_BIT] = flag;
            end
            tc8_pkg::OFS_IRQ_MASK:
            begin
                read_mux[tc8_pkg::IRQ_OVF_BIT] = enable;
            end
            default:
            begin
                read_mux = tc8_pkg::ZERO_BYTE;
            end
        endcase
    end

    always_comb
    begin
        s_nxt = s_r;

        // Phase sequencer
        unique case (s_r.phase)
            tc8_pkg::TC8_Q1:
            begin
                s_nxt.phase = tc8_pkg::TC8_Q2;
            end
            tc8_pkg::TC8_Q2:
            begin
                s_nxt.phase = tc8_pkg::TC8_Q3;
            end
            tc8_pkg::TC8_Q3:
            begin
                s_nxt.phase = tc8_pkg::TC8_Q4;
            end
            tc8_pkg::TC8_Q4:
            begin
                s_nxt.phase = tc8_pkg::TC8_Q1;
            end
        endcase

        // Pin synchroniser, only the second stage is looked at
        s_nxt.pin_s1   = external_count_pin;
        s_nxt.pin_s2   = s_r.pin_s1;
        s_nxt.pin_prev = s_r.pin_s2;

        // Pending external event waits for a sampling phase
        if (wr_count || !ext_mode)
        begin
            s_nxt.ext_pend = 1'b0;
        end
        else if (timer_event)
        begin
            s_nxt.ext_pend = 1'b1;
        end
        else if (sample_slot)
        begin
            s_nxt.ext_pend = 1'b0;
        end

        // Increment inhibit after a count write
        if (wr_count)
        begin
            s_nxt.hold = tc8_pkg::WRITE_HOLD_INSTR;
        end
        else if (instr_tick && (s_r.hold != tc8_pkg::HOLD_NONE))
        begin
            s_nxt.hold = s_r.hold - tc8_pkg::HOLD_ONE;
        end

        // Count register, software write beats an increment
        if (wr_count)
        begin
            s_nxt.count = bus_req.wdata;
        end
        else if (count_inc)
        begin
            s_nxt.count = s_r.count + tc8_pkg::ONE_BYTE;
        end

        if (wr_option)
        begin
            s_nxt.option = bus_req.wdata;
        end

        // Control flags; other bits are held for neighbouring logic
        if (wr_intctl)
        begin
            s_nxt.intctl = bus_req.wdata;
        end
        if (wr_mask)
        begin
            s_nxt.intctl[tc8_pkg::INT_ENABLE_BIT] =
                bus_req.wdata[tc8_pkg::IRQ_OVF_BIT];
        end
        if (wr_status && bus_req.wdata[tc8_pkg::IRQ_OVF_BIT])
        begin
            s_nxt.intctl[tc8_pkg::INT_FLAG_BIT] = 1'b0;
        end
        // Wrap sets the flag last so it wins over any clear
        if (overflow)
        begin
            s_nxt.intctl[tc8_pkg::INT_FLAG_BIT] = 1'b1;
        end

        // Read data valid only in the cycle after the strobe
        s_nxt.rdata = bus_req.rd ? read_mux : tc8_pkg::ZERO_BYTE;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            s_r <= tc8_pkg::CORE_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign bus_rdata = s_r.rdata;

    // Global gating is left to the interrupt controller outside
    assign irq = flag && enable;

endmodule

`default_nettype wire

/* File: verification/tc8_pin_src.sv */
`timescale 1ns/10ps
`default_nettype none

module tc8_pin_src (
    // Clock
    input  wire logic       ref_clk,
    // Command
    input  wire logic       go,
    input  wire logic [7:0] edges,
    input  wire logic [3:0] half,
    // Count pin
    output logic            pin,
    output logic            busy
);
    logic [7:0] left_r = 8'h00;
    logic [3:0] hold_r = 4'h0;
    logic [3:0] half_r = 4'h0;
    logic       lvl_r  = 1'b0;

    assign pin  = lvl_r;
    assign busy = (left_r != 8'h00);

    // Each level stays half+1 clocks, long enough for phase sampling
    always @(posedge ref_clk)
    begin
        if (go)
        begin
            left_r <= edges;
            half_r <= half;
            hold_r <= half;
        end
        else if (busy && hold_r != 4'h0)
            hold_r <= hold_r - 4'h1;
        else if (busy)
        begin
            lvl_r  <= ~lvl_r;
            left_r <= left_r - 8'h01;
            hold_r <= half_r;
        end
    end
endmodule

`default_nettype wire

/* File: verification/tc8_timer_asserts.sv */
`timescale 1ns/10ps
`default_nettype none

module tc8_timer_asserts (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  reset_n,
    // Register port
    input  wire tc8_pkg::tc8_bus_req_s bus_req,
    input  wire logic [7:0]            bus_rdata,
    // Pin, core, watchdog and interrupt
    input  wire logic                  external_count_pin,
    input  wire logic                  sleep_mode,
    input  wire logic                  watchdog_base_tick,
    input  wire logic                  watchdog_clear_instruction,
    input  wire logic                  watchdog_tick,
    input  wire logic                  irq
);
    wire logic [2:0] a = bus_req.addr;
    wire logic [7:0] d = bus_req.wdata;

    default clocking ck @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    rdata_idle_a:
        assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
        else $error("read data outside a read slot");
    unmapped_read_a:
        assert property ($past(bus_req.rd) && $past(a) > 3'h4
            |-> bus_rdata == 8'h00) else $error("unmapped read not zero");
    count_readback_a:
        assert property (bus_req.wr && a == tc8_pkg::OFS_COUNT ##1
            bus_req.rd && a == tc8_pkg::OFS_COUNT |=> bus_rdata == $past(d, 2))
        else $error("count read after write differs");
    option_readback_a:
        assert property (bus_req.wr && a == tc8_pkg::OFS_OPTION ##1
            bus_req.rd && a == tc8_pkg::OFS_OPTION |=> bus_rdata == $past(d, 2))
        else $error("option read after write differs");
    wd_tick_src_a:
        assert property (watchdog_tick |-> watchdog_base_tick)
        else $error("watchdog tick without base tick");
    irq_sticky_a:
        assert property (sleep_mode && !bus_req.wr |=> $stable(irq))
        else $error("irq moved while frozen and unwritten");
    irq_from_reg_a:
        assert property (bus_req.rd && a == tc8_pkg::OFS_INTCTL && sleep_mode
            |=> irq == (bus_rdata[2] && bus_rdata[5]))
        else $error("irq disagrees with flag and enable");
    intctl_write_a:
        assert property (bus_req.wr && a == tc8_pkg::OFS_INTCTL && sleep_mode
            |=> irq == $past(d[2] && d[5])) else $error("irq after flag write");
    status_clear_a:
        assert property (bus_req.wr && a == tc8_pkg::OFS_IRQ_STATUS && d[0]
            && sleep_mode |=> !irq) else $error("status clear left irq high");

    cover property (bus_req.rd && a == tc8_pkg::OFS_COUNT);
    cover property ($rose(irq));
    cover property (watchdog_tick);
endmodule

bind tc8_timer tc8_timer_asserts u_tc8_timer_asserts (
    .ref_clk(ref_clk), .reset_n(reset_n), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .external_count_pin(external_count_pin),
    .sleep_mode(sleep_mode), .watchdog_base_tick(watchdog_base_tick),
    .watchdog_clear_instruction(watchdog_clear_instruction),
    .watchdog_tick(watchdog_tick), .irq(irq));

`default_nettype wire

/* File: verification/tb_tc8_timer.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_tc8_timer;
    logic                  ref_clk = 1'b0;
    logic                  reset_n = 1'b0;
    tc8_pkg::tc8_bus_req_s req = '0;
    logic [7:0]            bus_rdata;
    logic                  pin, wtick, irq, src_busy;
    logic                  sleep_mode = 1'b0, base = 1'b0, wclr = 1'b0;
    logic                  src_go = 1'b0, rd_pend = 1'b0, pin_lvl = 1'b0;
    logic [7:0]            src_n = 8'h00, opt;
    logic [3:0]            src_h = 4'h3;
    logic [7:0]            exp_q[$];
    int                    failures = 0, checked = 0, wt_cnt = 0;
    int                    seed = 32'h5d7b103c, i, k, m, n, r, c;

    always #5 ref_clk = ~ref_clk;

    tc8_timer u_tc8_timer (.ref_clk(ref_clk), .reset_n(reset_n),
        .bus_req(req), .bus_rdata(bus_rdata), .external_count_pin(pin),
        .sleep_mode(sleep_mode), .watchdog_base_tick(base),
        .watchdog_clear_instruction(wclr), .watchdog_tick(wtick), .irq(irq));
    tc8_pin_src u_tc8_pin_src (.ref_clk(ref_clk), .go(src_go),
        .edges(src_n), .half(src_h), .pin(pin), .busy(src_busy));

    task automatic compare(input string what, input logic [7:0] e,
                           input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
    endtask
    task automatic idle(input int cyc);
        req <= '0;
        repeat (cyc) @(posedge ref_clk);
    endtask
    // Count window is phase free: 4m edges hold exactly m ticks
    task automatic timed(input logic [7:0] o, input logic [7:0] d,
                         input int cyc, input int inc);
        logic [8:0] s;
        s = {1'b0, d} + 9'(inc);
        wr(3'h0, o);
        sleep_mode <= 1'b0;
        wr(3'h1, d);
        idle(4 * cyc);
        sleep_mode <= 1'b1;
        rd(3'h1, s[7:0]);
        rd(3'h2, {5'h00, s[8], 2'h0});
        wr(3'h2, 8'h00);
    endtask
    task automatic pulse_base(input int cnt);
        repeat (cnt)
        begin
            base <= 1'b1;
            @(posedge ref_clk);
            base <= 1'b0;
            @(posedge ref_clk);
        end
    endtask
    task automatic wd_clear;
        req <= '0;
        wclr <= 1'b1;
        @(posedge ref_clk);
        wclr <= 1'b0;
    endtask
    task automatic complete_run;
        if (failures == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        if (rd_pend)
            compare("read data", exp_q.pop_front(), bus_rdata);
        rd_pend <= req.rd;
        if (wtick)
            wt_cnt++;
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        complete_run();
    end

    initial
    begin
        logic [2:0] ia [6] = '{3'h2, 3'h4, 3'h4, 3'h2, 3'h3, 3'h2};
        logic [7:0] id [6] = '{8'h04, 8'h01, 8'h00, 8'h24, 8'h01, 8'h00};
        logic [7:0] wo [4] = '{8'h0a, 8'h08, 8'h00, 8'h0f};
        int         wp [4] = '{2, 1, 1, 3};
        int         wq [4] = '{6, 3, 3, 127};
        int         we [4] = '{1, 3, 3, 0};
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        sleep_mode <= 1'b1;
        for (i = 0; i < 8; i++)
            rd(i[2:0], (i == 0) ? 8'hff : 8'h00);
        wr(3'h5, 8'hff);
        rd(3'h5, 8'h00);
        wr(3'h0, 8'hc8);
        rd(3'h0, 8'hc8);
        opt = 8'($random(seed));
        wr(3'h1, opt);
        rd(3'h1, opt);
        timed(8'h08, 8'hff, 3, 1);
        for (i = 0; i < 2; i++)
        begin
            m = 3 + ($random(seed) & 15);
            timed(8'h08, 8'($random(seed)), m, m - 2);
        end
        for (i = 0; i < 8; i++)
            timed({5'h00, i[2:0]}, 8'($random(seed)), 3 * (2 << i) + 2, 3);
        for (i = 0; i < 6; i++)
        begin
            wr(ia[i], id[i]);
            idle(1);
            compare("irq", {7'h00, id[i] == 8'h01 && i == 1 || i == 3},
                    {7'h00, irq});
            if (i == 3)
                rd(3'h3, 8'h01);
            if (i == 4)
                rd(3'h2, 8'h20);
        end
        for (i = 0; i < 4; i++)
        begin
            wd_clear();
            wr(3'h1, 8'h00);
            wr(3'h0, wo[i] & 8'hf8);
            wd_clear();
            wr(3'h0, wo[i]);
            idle(1);
            pulse_base(wp[i]);
            wd_clear();
            m = wt_cnt;
            pulse_base(wq[i]);
            c = wt_cnt - m;
            compare("watchdog ticks", we[i][7:0], c[7:0]);
        end
        for (i = 0; i < 4; i++)
        begin
            n = 3 + ($random(seed) & 7);
            r = pin_lvl ? n / 2 : (n + 1) / 2;
            c = i[0] ? n - r : r;
            c = i[1] ? c / 2 : c;
            sleep_mode <= 1'b0;
            wr(3'h0, {3'b001, i[0], ~i[1], 3'b000});
            idle(8);
            wr(3'h1, 8'h00);
            idle(12);
            src_n <= n[7:0];
            src_h <= 4'(3 + ($random(seed) & 7));
            src_go <= 1'b1;
            @(posedge ref_clk);
            src_go <= 1'b0;
            idle(2);
            for (k = 0; k < 400 && src_busy; k++)
                @(posedge ref_clk);
            idle(8);
            sleep_mode <= 1'b1;
            rd(3'h1, c[7:0]);
            pin_lvl ^= n[0];
        end
        idle(2);
        complete_run();
    end
endmodule

`default_nettype wire
